// file: core/dpas_top.sv
// debug and test port access select: pin pairs, key window, lockout
`timescale 1ns/100ps
`include "dpas_map.svh"
// Behaviour
// - four-pin test port, optional test reset
// - test port on by default, config disables
// - test port: flash, debug, scan, chaining
// - two-wire port on test or usb pins
// - one pin clocks, other carries data both ways
// - two-wire port on one pair only
// - pair enabled by key in window, test pair also by instruction
// - test port enables two-wire, or disabled
// - key window always reacquires; reenables test port
// - scan and chaining only through test port
// - two-wire gives same debug path, speed
// - debug modules off after reset, firmware enables
// - no probe path re-enables debug modules
// - lockout disables every external access
// - lockout sampled at reset, 28 of 32
// - new key acts only after reset
module dpas_top #(
   parameter logic [31:0] IDCODE = 32'h10020001, // arbitrary value
   parameter logic [31:0] LOCK_PATTERN = 32'h3c5a96e1 // arbitrary value
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // test access port pins
   input wire logic tckPin,
   input wire logic tmsPin,
   output logic tmsOut,
   output logic tmsOe,
   input wire logic tdiPin,
   output logic tdoOut,
   output logic tdoOe,
   input wire logic ntrstPin,
   // usb data pins
   input wire logic usbDpPin,
   output logic usbDpOut,
   output logic usbDpOe,
   input wire logic usbDmPin,
   // configuration and nonvolatile state
   input wire logic jtagCfgDisable,
   input wire logic swdCfgDisable,
   input wire logic [31:0] lockCells,
   input wire logic fwDbgEnable,
   // debug engine side
   input wire logic swdOutBit,
   input wire logic swdOutEn,
   input wire logic swdJtagReenable,
   input wire logic bsChainOut,
   input wire logic dbgChainOut,
   output logic swdBitStrobe,
   output logic swdBitIn,
   output logic tdiBit,
   output logic bsCapture,
   output logic bsShift,
   output logic bsUpdate,
   output logic dbgCapture,
   output logic dbgShift,
   output logic dbgUpdate,
   // status
   output logic jtagActive,
   output dpas_pkg::dpas_pair_t swdSel,
   output logic keyWindowOpen,
   output logic lockedOut,
   output logic dbgModEnable
);
   // ----------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // ----------------------------------------------------------------
   logic [5:0] pinS1, pinS2, pinS3, pinLvl, lvlPrev;
   logic [5:0] pinRaw;
   assign pinRaw = {usbDmPin, usbDpPin, ntrstPin, tdiPin, tmsPin, tckPin};

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pinS1 <= `DPAS_PIN_RST;
         pinS2 <= `DPAS_PIN_RST;
         pinS3 <= `DPAS_PIN_RST;
         pinLvl <= `DPAS_PIN_RST;
         lvlPrev <= `DPAS_PIN_RST;
      end else begin
         pinS1 <= pinRaw;
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         pinLvl <= (pinS2 & pinS3) | (pinLvl & (pinS2 ^ pinS3));
         lvlPrev <= pinLvl;
      end
   end

   logic tckRise, tckFall;
   assign tckRise = pinLvl[`DPAS_PIN_TCK] & ~lvlPrev[`DPAS_PIN_TCK];
   assign tckFall = ~pinLvl[`DPAS_PIN_TCK] & lvlPrev[`DPAS_PIN_TCK];

   // ----------------------------------------------------------------
   // lockout latch, sampled once after reset release
   // ----------------------------------------------------------------
   function automatic logic [5:0] agreeCount(input logic [31:0] v);
      logic [5:0] n;
      n = 6'd0;
      for (int i = 0; i < `DPAS_LOCK_BITS; i++) begin
         n = n + {5'd0, v[i]};
      end
      return n;
   endfunction

   logic lockDone, lockHit;
   assign lockHit = agreeCount(~(lockCells ^ LOCK_PATTERN)) >= `DPAS_LOCK_MATCH_MIN;

   // cells are only looked at here, so a freshly written key waits for reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lockDone <= 1'b0;
         lockedOut <= 1'b1; // safe until sampled
      end else if (!lockDone) begin
         lockDone <= 1'b1;
         lockedOut <= lockHit;
      end
   end

   logic accessOk;
   assign accessOk = lockDone & ~lockedOut;

   // ----------------------------------------------------------------
   // key window and the two detectors
   // ----------------------------------------------------------------
   logic [`DPAS_WIN_CNT_W-1:0] winCnt;
   logic keyAcq;
   logic [1:0] keyMatch;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         winCnt <= '0;
      end else if (winCnt < `DPAS_WIN_CNT_W'(`DPAS_KEY_WIN_CYC)) begin
         winCnt <= winCnt + 1'b1;
      end
   end

   // window ignores configuration; lockout, an acquired pair or the timer close it
   assign keyWindowOpen = accessOk && !keyAcq
      && (winCnt < `DPAS_WIN_CNT_W'(`DPAS_KEY_WIN_CYC));

   dpas_key_if kif[2] ();

   generate
      for (genvar g = 0; g < 2; g++) begin : gPair
         assign kif[g].clkLvl = (g == 0) ? pinLvl[`DPAS_PIN_TCK] : pinLvl[`DPAS_PIN_DM];
         assign kif[g].dataLvl = (g == 0) ? pinLvl[`DPAS_PIN_TMS] : pinLvl[`DPAS_PIN_DP];
         assign kif[g].windowOpen = keyWindowOpen;
         assign keyMatch[g] = kif[g].match;
         dpas_key_det uDet (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .kif(kif[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // pair selection and test port enable
   // ----------------------------------------------------------------
   dpas_pkg::dpas_tap_t tap, next_tap;
   logic [3:0] ir, irShift;
   logic jtagForce, jtagOn;

   assign jtagOn = accessOk && (swdSel != dpas_pkg::SWD_JTAG)
      && (!jtagCfgDisable || jtagForce);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         swdSel <= dpas_pkg::SWD_NONE;
         keyAcq <= 1'b0;
         jtagForce <= 1'b0;
      end else if (!accessOk) begin
         swdSel <= dpas_pkg::SWD_NONE;
      end else if (keyWindowOpen && keyMatch[0]) begin
         swdSel <= dpas_pkg::SWD_JTAG;
         keyAcq <= 1'b1;
      end else if (keyWindowOpen && keyMatch[1]) begin
         swdSel <= dpas_pkg::SWD_USB;
         keyAcq <= 1'b1;
      end else if (swdSel != dpas_pkg::SWD_NONE && swdJtagReenable) begin
         jtagForce <= 1'b1;
         if (swdSel == dpas_pkg::SWD_JTAG) begin
            swdSel <= dpas_pkg::SWD_NONE;
         end
      end else if (jtagOn && tckRise && tap == dpas_pkg::TAP_UPIR
                   && irShift == `DPAS_IR_SWDSEL && !swdCfgDisable) begin
         swdSel <= dpas_pkg::SWD_JTAG;
      end else if (swdCfgDisable && !keyAcq) begin
         swdSel <= dpas_pkg::SWD_NONE;
      end
   end

   // ----------------------------------------------------------------
   // two-wire bit path: clock pin in, data pin both ways
   // ----------------------------------------------------------------
   logic swdRise;
   assign swdRise = (swdSel == dpas_pkg::SWD_JTAG)
      ? (pinLvl[`DPAS_PIN_TCK] & ~lvlPrev[`DPAS_PIN_TCK])
      : (pinLvl[`DPAS_PIN_DM] & ~lvlPrev[`DPAS_PIN_DM]);

   // own engine strobe, swdBitStrobe with swdBitIn, one bit per probe clock
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         swdBitStrobe <= 1'b0;
         swdBitIn <= 1'b0;
         tmsOut <= 1'b0;
         tmsOe <= 1'b0;
         usbDpOut <= 1'b0;
         usbDpOe <= 1'b0;
      end else begin
         swdBitStrobe <= swdRise && swdSel != dpas_pkg::SWD_NONE;
         swdBitIn <= (swdSel == dpas_pkg::SWD_JTAG) ? pinLvl[`DPAS_PIN_TMS]
                                                    : pinLvl[`DPAS_PIN_DP];
         tmsOut <= swdOutBit;
         usbDpOut <= swdOutBit;
         tmsOe <= swdOutEn && swdSel == dpas_pkg::SWD_JTAG;
         usbDpOe <= swdOutEn && swdSel == dpas_pkg::SWD_USB;
      end
   end

   // ----------------------------------------------------------------
   // test access port controller
   // ----------------------------------------------------------------
   always_comb begin
      logic m;
      m = pinLvl[`DPAS_PIN_TMS];
      case (tap)
         dpas_pkg::TAP_TLR: next_tap = m ? dpas_pkg::TAP_TLR : dpas_pkg::TAP_RTI;
         dpas_pkg::TAP_RTI: next_tap = m ? dpas_pkg::TAP_SELDR : dpas_pkg::TAP_RTI;
         dpas_pkg::TAP_SELDR: next_tap = m ? dpas_pkg::TAP_SELIR : dpas_pkg::TAP_CAPDR;
         dpas_pkg::TAP_CAPDR: next_tap = m ? dpas_pkg::TAP_EX1DR : dpas_pkg::TAP_SHDR;
         dpas_pkg::TAP_SHDR: next_tap = m ? dpas_pkg::TAP_EX1DR : dpas_pkg::TAP_SHDR;
         dpas_pkg::TAP_EX1DR: next_tap = m ? dpas_pkg::TAP_UPDR : dpas_pkg::TAP_PDR;
         dpas_pkg::TAP_PDR: next_tap = m ? dpas_pkg::TAP_EX2DR : dpas_pkg::TAP_PDR;
         dpas_pkg::TAP_EX2DR: next_tap = m ? dpas_pkg::TAP_UPDR : dpas_pkg::TAP_SHDR;
         dpas_pkg::TAP_UPDR: next_tap = m ? dpas_pkg::TAP_SELDR : dpas_pkg::TAP_RTI;
         dpas_pkg::TAP_SELIR: next_tap = m ? dpas_pkg::TAP_TLR : dpas_pkg::TAP_CAPIR;
         dpas_pkg::TAP_CAPIR: next_tap = m ? dpas_pkg::TAP_EX1IR : dpas_pkg::TAP_SHIR;
         dpas_pkg::TAP_SHIR: next_tap = m ? dpas_pkg::TAP_EX1IR : dpas_pkg::TAP_SHIR;
         dpas_pkg::TAP_EX1IR: next_tap = m ? dpas_pkg::TAP_UPIR : dpas_pkg::TAP_PIR;
         dpas_pkg::TAP_PIR: next_tap = m ? dpas_pkg::TAP_EX2IR : dpas_pkg::TAP_PIR;
         dpas_pkg::TAP_EX2IR: next_tap = m ? dpas_pkg::TAP_UPIR : dpas_pkg::TAP_SHIR;
         dpas_pkg::TAP_UPIR: next_tap = m ? dpas_pkg::TAP_SELDR : dpas_pkg::TAP_RTI;
         default: next_tap = dpas_pkg::TAP_TLR;
      endcase
   end

   // optional test reset pin, idle high when left open
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tap <= dpas_pkg::TAP_TLR;
      end else if (!jtagOn || !pinLvl[`DPAS_PIN_NTRST]) begin
         tap <= dpas_pkg::TAP_TLR;
      end else if (tckRise) begin
         tap <= next_tap;
      end
   end

   // ----------------------------------------------------------------
   // instruction and data registers; scan chain only reachable here
   // ----------------------------------------------------------------
   logic bypassBit;
   logic [31:0] idShift;
   logic isBs, isDbg, tdi;
   assign isBs = (ir == `DPAS_IR_EXTEST) || (ir == `DPAS_IR_SAMPLE);
   assign isDbg = (ir == `DPAS_IR_DEBUG);
   assign tdi = pinLvl[`DPAS_PIN_TDI];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ir <= `DPAS_IR_IDCODE;
         irShift <= `DPAS_IR_CAPTURE;
         bypassBit <= 1'b0;
         idShift <= 32'h00000000;
         {bsCapture, bsShift, bsUpdate} <= 3'h0;
         {dbgCapture, dbgShift, dbgUpdate} <= 3'h0;
         tdiBit <= 1'b0;
      end else begin
         bsCapture <= jtagOn && tckRise && isBs && tap == dpas_pkg::TAP_CAPDR;
         bsShift <= jtagOn && tckRise && isBs && tap == dpas_pkg::TAP_SHDR;
         bsUpdate <= jtagOn && tckRise && isBs && tap == dpas_pkg::TAP_UPDR;
         dbgCapture <= jtagOn && tckRise && isDbg && tap == dpas_pkg::TAP_CAPDR;
         dbgShift <= jtagOn && tckRise && isDbg && tap == dpas_pkg::TAP_SHDR;
         dbgUpdate <= jtagOn && tckRise && isDbg && tap == dpas_pkg::TAP_UPDR;
         tdiBit <= tdi;
         if (!jtagOn || tap == dpas_pkg::TAP_TLR) begin
            ir <= `DPAS_IR_IDCODE;
         end else if (tckRise) begin
            case (tap)
               dpas_pkg::TAP_CAPIR: irShift <= `DPAS_IR_CAPTURE;
               dpas_pkg::TAP_SHIR: irShift <= {tdi, irShift[3:1]};
               dpas_pkg::TAP_UPIR: ir <= irShift;
               dpas_pkg::TAP_CAPDR: begin
                  bypassBit <= 1'b0;
                  idShift <= IDCODE;
               end
               dpas_pkg::TAP_SHDR: begin
                  bypassBit <= tdi; // chaining
                  idShift <= {tdi, idShift[31:1]};
               end
               default: bypassBit <= bypassBit;
            endcase
         end
      end
   end

   // output changes on the falling test clock, as chained parts expect
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tdoOut <= 1'b0;
         tdoOe <= 1'b0;
      end else if (!jtagOn) begin
         tdoOe <= 1'b0;
      end else if (tckFall) begin
         tdoOe <= (tap == dpas_pkg::TAP_SHIR) || (tap == dpas_pkg::TAP_SHDR);
         if (tap == dpas_pkg::TAP_SHIR) begin
            tdoOut <= irShift[0];
         end else if (isBs) begin
            tdoOut <= bsChainOut;
         end else if (isDbg) begin
            tdoOut <= dbgChainOut;
         end else if (ir == `DPAS_IR_IDCODE) begin
            tdoOut <= idShift[0];
         end else begin
            tdoOut <= bypassBit;
         end
      end
   end

   // ----------------------------------------------------------------
   // status and debug module enable
   // ----------------------------------------------------------------
   // only the cpu can raise the enable; reset alone lowers it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         jtagActive <= 1'b0;
         dbgModEnable <= 1'b0;
      end else begin
         jtagActive <= jtagOn;
         if (fwDbgEnable) begin
            dbgModEnable <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   AST_LOCK_CLOSES_ALL: assert property (lockedOut |=> !jtagActive && !tmsOe && !usbDpOe
      && swdSel == dpas_pkg::SWD_NONE)
      else $error("access open while locked");
   AST_ONE_PAIR: assert property (!(tmsOe && usbDpOe))
      else $error("both pairs driven");
   AST_KEY_IN_WINDOW: assert property ($rose(keyAcq)
      |-> $past(winCnt) < `DPAS_WIN_CNT_W'(`DPAS_KEY_WIN_CYC) && $past(keyMatch) != 2'b00)
      else $error("pair acquired outside window");
   AST_DBG_ONLY_FW: assert property ($rose(dbgModEnable) |-> $past(fwDbgEnable))
      else $error("debug modules enabled without firmware");
   AST_JTAG_DEFAULT: assert property (accessOk && !jtagCfgDisable
      && swdSel == dpas_pkg::SWD_NONE |=> jtagActive)
      else $error("test port not enabled by default");
   AST_SCAN_ONLY_JTAG: assert property (bsShift || bsCapture || bsUpdate |-> $past(jtagOn)
      && $past(swdSel) != dpas_pkg::SWD_JTAG)
      else $error("scan strobe without test port");
   AST_LOCK_SAMPLE: assert property ($rose(lockDone) |-> lockedOut == $past(lockHit))
      else $error("lockout sample wrong");
   AST_LOCK_STABLE: assert property (lockDone && $past(lockDone) |-> $stable(lockedOut))
      else $error("lockout changed after sampling");
   AST_TRST: assert property (!pinLvl[`DPAS_PIN_NTRST] |=> tap == dpas_pkg::TAP_TLR)
      else $error("test reset ignored");
   AST_SWD_STROBE: assert property (swdBitStrobe |-> $past(swdSel) != dpas_pkg::SWD_NONE)
      else $error("bit strobe with no pair");
endmodule

// file: core/dpas_map.svh
// constant map for the debug port access select block
`ifndef DPAS_MAP_SVH
`define DPAS_MAP_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPAS_CLK_PERIOD_NS 8
`define DPAS_KEY_WIN_NS 8000
`define DPAS_KEY_WIN_CYC (`DPAS_KEY_WIN_NS / `DPAS_CLK_PERIOD_NS)
`define DPAS_WIN_CNT_W 10
// ----------------------------------------------------------------
// keys and lockout
// ----------------------------------------------------------------
`define DPAS_SWD_KEY 32'h6209e79e
`define DPAS_LOCK_BITS 32
`define DPAS_LOCK_MATCH_MIN 6'd28
// ----------------------------------------------------------------
// pin vector positions and reset level
// ----------------------------------------------------------------
`define DPAS_PIN_TCK 0
`define DPAS_PIN_TMS 1
`define DPAS_PIN_TDI 2
`define DPAS_PIN_NTRST 3
`define DPAS_PIN_DP 4
`define DPAS_PIN_DM 5
`define DPAS_PIN_RST 6'h08
// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define DPAS_IR_EXTEST 4'h0
`define DPAS_IR_IDCODE 4'h1
`define DPAS_IR_SAMPLE 4'h2
`define DPAS_IR_DEBUG 4'h8
`define DPAS_IR_SWDSEL 4'h9
`define DPAS_IR_BYPASS 4'hf
`define DPAS_IR_CAPTURE 4'h1
`endif

// file: core/dpas_pkg.sv
// types of the debug port access select block
package dpas_pkg;
   // test access port controller, gray coded along the usual walk
   typedef enum logic [3:0] {
      TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SELDR = 4'h3, TAP_CAPDR = 4'h2,
      TAP_SHDR = 4'h6, TAP_EX1DR = 4'h7, TAP_PDR = 4'h5, TAP_EX2DR = 4'h4,
      TAP_UPDR = 4'hc, TAP_SELIR = 4'hd, TAP_CAPIR = 4'hf, TAP_SHIR = 4'he,
      TAP_EX1IR = 4'ha, TAP_PIR = 4'hb, TAP_EX2IR = 4'h9, TAP_UPIR = 4'h8
   } dpas_tap_t;
   // which pin pair carries the two-wire port
   typedef enum logic [1:0] {
      SWD_NONE = 2'h0, SWD_JTAG = 2'h1, SWD_USB = 2'h3
   } dpas_pair_t;
endpackage

// file: core/dpas_key_if.sv
// link between the selector and one key detector
`timescale 1ns/100ps
interface dpas_key_if;
   logic clkLvl;
   logic dataLvl;
   logic windowOpen;
   logic match;
   modport det (input clkLvl, input dataLvl, input windowOpen, output match);
   modport sel (output clkLvl, output dataLvl, output windowOpen, input match);
endinterface

// file: core/dpas_key_det.sv
// key sequence detector for one candidate pin pair
`timescale 1ns/100ps
`include "dpas_map.svh"
module dpas_key_det (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // filtered pair levels and result
   dpas_key_if.det kif
);
   logic clkPrev;
   logic [31:0] keyShift;
   logic [31:0] next_keyShift;
   logic hit;

   assign next_keyShift = {keyShift[30:0], kif.dataLvl};
   assign kif.match = hit;

   // ----------------------------------------------------------------
   // shift on each probe clock rise, only inside the window
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         clkPrev <= 1'b0;
         keyShift <= 32'h00000000;
         hit <= 1'b0;
      end else begin
         clkPrev <= kif.clkLvl;
         hit <= 1'b0;
         if (kif.windowOpen && kif.clkLvl && !clkPrev) begin
            keyShift <= next_keyShift;
            hit <= (next_keyShift == `DPAS_SWD_KEY);
         end
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   AST_MATCH_IN_WINDOW: assert property (hit |-> $past(kif.windowOpen))
      else $error("key match outside window");
endmodule

// file: tb/dpas_probe.sv
// probe model: sends the two-wire key on one pin pair
`timescale 1ns/100ps
module dpas_probe (
   // pacing reference
   input wire logic ref_clk,
   // pin pair driven by the probe
   output logic clkPin,
   output logic dataPin
);
   // -----------------------------------------------
   // key sender
   // -----------------------------------------------
   // half period in reference cycles: 160 ns probe clock, well under a third of ref_clk
   localparam int HALF = 10;
   initial begin
      clkPin = 1'b0;
      dataPin = 1'b0;
   end
   // msb first, data moves with the clock fall so it is steady at the rise
   task automatic send(input logic [31:0] k);
      for (int i = 31; i >= 0; i--) begin
         clkPin = 1'b0;
         dataPin = k[i];
         repeat (HALF) @(negedge ref_clk);
         clkPin = 1'b1;
         repeat (HALF) @(negedge ref_clk);
      end
      clkPin = 1'b0; // clock stands still between frames
      dataPin = ~dataPin; // released line must not show the last bit
   endtask
endmodule

// file: tb/test_debug_port_access_select.sv
// self-checking bench for the debug port access select block
`timescale 1ns/100ps
`include "dpas_map.svh"
module test_debug_port_access_select;
   // -----------------------------------------------
   // signals and instances
   // -----------------------------------------------
   localparam logic [31:0] LOCK = 32'h3c5a96e1; // arbitrary value
   localparam logic [31:0] KEY = `DPAS_SWD_KEY;
   localparam logic [31:0] IDC = 32'h0badc0de; // arbitrary value
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic jClk, jData, uClk, uData;
   logic tmsPin, usbDpPin;
   logic tmsOut, tmsOe, tdoOut, tdoOe, usbDpOut, usbDpOe;
   logic jtagCfgDisable = 1'b0;
   logic swdCfgDisable = 1'b0;
   logic [31:0] lockCells = 32'h0;
   logic fwDbgEnable = 1'b0;
   logic swdOutEn = 1'b0;
   logic swdOutBit = 1'b1;
   logic tdi = 1'b0;
   logic swdBitStrobe, swdBitIn, tdiBit;
   logic [31:0] bitsIn = 32'h0;
   int nStrobe = 0;
   logic swdJtagReenable = 1'b0;
   logic jtagActive, keyWindowOpen, lockedOut, dbgModEnable;
   dpas_pkg::dpas_pair_t swdSel;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   // data pins resolve from both drivers; the design wins while its enable is high
   assign tmsPin = tmsOe ? tmsOut : jData;
   assign usbDpPin = usbDpOe ? usbDpOut : uData;
   dpas_probe pj (.ref_clk(ref_clk), .clkPin(jClk), .dataPin(jData));
   dpas_probe pu (.ref_clk(ref_clk), .clkPin(uClk), .dataPin(uData));
   dpas_top #(.IDCODE(IDC), .LOCK_PATTERN(LOCK)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .tckPin(jClk), .tmsPin(tmsPin), .tmsOut(tmsOut),
      .tmsOe(tmsOe), .tdiPin(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .ntrstPin(1'b1),
      .usbDpPin(usbDpPin), .usbDpOut(usbDpOut), .usbDpOe(usbDpOe), .usbDmPin(uClk),
      .jtagCfgDisable(jtagCfgDisable), .swdCfgDisable(swdCfgDisable),
      .lockCells(lockCells), .fwDbgEnable(fwDbgEnable), .swdOutBit(swdOutBit),
      .swdOutEn(swdOutEn), .swdJtagReenable(swdJtagReenable), .bsChainOut(1'b0),
      .dbgChainOut(1'b0), .swdBitStrobe(swdBitStrobe), .swdBitIn(swdBitIn),
      .tdiBit(tdiBit), .bsCapture(),
      .bsShift(), .bsUpdate(), .dbgCapture(), .dbgShift(), .dbgUpdate(),
      .jtagActive(jtagActive), .swdSel(swdSel), .keyWindowOpen(keyWindowOpen),
      .lockedOut(lockedOut), .dbgModEnable(dbgModEnable));
   // 125 MHz clock
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // gather two-wire bits as the design hands them over; strobe stands one full cycle
   always @(negedge ref_clk) begin
      if (swdBitStrobe === 1'b1) begin
         nStrobe++;
         bitsIn = {bitsIn[30:0], swdBitIn};
      end
   end
   // hang guard: the whole run needs about 6300 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         finish_test();
      end
   end
   // -----------------------------------------------
   // shared tasks
   // -----------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // reset for 10 cycles with the given lock cells, release on a falling edge
   task automatic do_reset(input logic [31:0] cells);
      @(negedge ref_clk);
      nrst = 1'b0;
      lockCells = cells;
      repeat (10) @(negedge ref_clk);
      check("lockedOut in reset", lockedOut, 1);
      nrst = 1'b1;
      repeat (2) @(negedge ref_clk);
   endtask
   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   task automatic t_defaults();
      do_reset(32'h0);
      check("jtagActive", jtagActive, 1);
      check("keyWindowOpen", keyWindowOpen, 1);
      check("swdSel", swdSel, dpas_pkg::SWD_NONE);
      check("dbgModEnable", dbgModEnable, 0);
      fwDbgEnable = 1'b1;
      @(negedge ref_clk);
      fwDbgEnable = 1'b0;
      repeat (`DPAS_KEY_WIN_CYC) @(negedge ref_clk);
      check("dbgModEnable sticky", dbgModEnable, 1);
      check("keyWindowOpen late", keyWindowOpen, 0);
      pu.send(KEY);
      repeat (10) @(negedge ref_clk);
      check("swdSel late key", swdSel, dpas_pkg::SWD_NONE);
   endtask
   // both pairs get the key at once: only the test pair may take the port
   task automatic t_both_pairs();
      do_reset(32'h0);
      fork
         pj.send(KEY);
         pu.send(KEY);
      join
      repeat (8) @(negedge ref_clk);
      check("swdSel both", swdSel, dpas_pkg::SWD_JTAG);
      check("keyWindowOpen closed", keyWindowOpen, 0);
      swdOutEn = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("tmsOe", tmsOe, 1);
      check("tmsOut", tmsOut, 1);
      check("usbDpOe", usbDpOe, 0);
      swdOutEn = 1'b0;
   endtask
   task automatic t_usb_and_bad();
      int n0;
      do_reset(32'h0);
      pj.send(KEY ^ 32'h1);
      repeat (8) @(negedge ref_clk);
      check("swdSel bad key", swdSel, dpas_pkg::SWD_NONE);
      check("window open", keyWindowOpen, 1);
      do_reset(32'h0);
      pu.send(KEY);
      repeat (8) @(negedge ref_clk);
      check("swdSel usb", swdSel, dpas_pkg::SWD_USB);
      n0 = nStrobe;
      swdOutBit = 1'b0;
      swdOutEn = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("usbDpOe", usbDpOe, 1);
      check("usbDpOut", usbDpOut, 0);
      check("tmsOe usb", tmsOe, 0);
      swdOutEn = 1'b0;
      swdOutBit = 1'b1;
      // a full frame on the acquired pair must come through bit for bit
      pu.send(KEY);
      repeat (8) @(negedge ref_clk);
      check("swdBitStrobe count", nStrobe - n0, 32);
      check("swdBitIn", bitsIn, KEY);
   endtask
   // disabled configuration must not stop the key; the port then restores the test port
   task automatic t_config();
      jtagCfgDisable = 1'b1;
      swdCfgDisable = 1'b1;
      do_reset(32'h0);
      check("jtagActive disabled", jtagActive, 0);
      pj.send(KEY);
      repeat (8) @(negedge ref_clk);
      check("swdSel reacquire", swdSel, dpas_pkg::SWD_JTAG);
      swdJtagReenable = 1'b1;
      @(negedge ref_clk);
      swdJtagReenable = 1'b0;
      repeat (4) @(negedge ref_clk);
      check("jtagActive reenabled", jtagActive, 1);
      check("swdSel released", swdSel, dpas_pkg::SWD_NONE);
      jtagCfgDisable = 1'b0;
      swdCfgDisable = 1'b0;
   endtask
   task automatic t_lockout();
      do_reset(LOCK ^ 32'h0000000f);
      check("lockedOut 28", lockedOut, 1);
      check("jtagActive locked", jtagActive, 0);
      check("window locked", keyWindowOpen, 0);
      pu.send(KEY);
      repeat (8) @(negedge ref_clk);
      check("swdSel locked", swdSel, dpas_pkg::SWD_NONE);
      do_reset(LOCK ^ 32'h0000001f);
      check("lockedOut 27", lockedOut, 0);
      lockCells = LOCK;
      repeat (20) @(negedge ref_clk);
      check("lockedOut new key", lockedOut, 0);
      check("jtagActive new key", jtagActive, 1);
      // mode walk on the test pins: stay in reset, idle, then 27 shifts of the id
      tdi = 1'b1;
      pj.send(32'ha0000000);
      repeat (8) @(negedge ref_clk);
      check("tdiBit", tdiBit, 1);
      check("tdoOe shift", tdoOe, 1);
      check("tdoOut id bit", tdoOut, IDC[27]);
      tdi = 1'b0;
      do_reset(LOCK);
      check("lockedOut after reset", lockedOut, 1);
   endtask
   // -----------------------------------------------
   // main sequence
   // -----------------------------------------------
   initial begin
      t_defaults();
      t_both_pairs();
      t_usb_and_bad();
      t_config();
      t_lockout();
      finish_test();
   end
endmodule
